// file: core/mwc_pkg.sv
// Purpose: Shared constants and types for the motion-watch configuration block
// Assumes: 8-bit register port, byte-wide accesses at documented offsets
// Notes:   Every offset, field position and reset value lives here
package mwc_pkg;

  localparam logic [7:0] MWC_CONFIG_OFFSET = 8'h14;
  localparam logic [7:0] MWC_VALUE_OFFSET  = 8'h13;
  localparam logic [7:0] MWC_CONFIG_RESET  = 8'h00;
  localparam logic [5:0] MWC_SHADOW_RESET  = 6'h00;

  // Field positions in motion_watch_config
  localparam int MWC_IDX_LSB   = 0;
  localparam int MWC_CNTEN_BIT = 3;
  localparam int MWC_MUX_LSB   = 4;
  localparam int MWC_RESET_BIT = 7;

  localparam int MWC_DELTA_W = 11;
  localparam int MWC_VAL_W   = 6;

  // Shadow index codes
  localparam logic [2:0] MWC_IDX_TH_X  = 3'h1;
  localparam logic [2:0] MWC_IDX_TH_Y  = 3'h2;
  localparam logic [2:0] MWC_IDX_TH_Z  = 3'h3;
  localparam logic [2:0] MWC_IDX_CNT_X = 3'h5;
  localparam logic [2:0] MWC_IDX_CNT_Y = 3'h6;
  localparam logic [2:0] MWC_IDX_CNT_Z = 3'h7;

  // Decoded configuration register
  typedef struct packed {
    logic       block_reset;
    logic [2:0] delta_slice_select;
    logic       detect_count_enable;
    logic [2:0] shadow_index_select;
  } mwc_config_type;

  // Register port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mwc_req_type;

  // Per-axis deltas, magnitudes
  typedef struct packed {
    logic [10:0] x;
    logic [10:0] y;
    logic [10:0] z;
  } mwc_delta_type;

endpackage

// file: core/mwc_motion_watch_config.sv
// Operation
// - Index 1-3,5,6 route value register; 0,4 none
// - Index 7 reaches Z event count
// - Count enable bit 3 gates event counters
// - Selector picks 6-bit window of delta
// - Oversize delta saturates window, still detected
// - Bit 7 holds block reset, never self-clears
//
// Purpose: Motion-watch config register, shadow values, per-axis window compare
// Assumes: Deltas are unsigned magnitudes, one strobe per new sample
// Notes:   Byte-wide register port; unmapped reads return zero
module mwc_motion_watch_config (
  input  wire logic                   mclk_in,
  input  wire logic                   arst_n_in,
  input  wire mwc_pkg::mwc_req_type   req_in,
  input  wire mwc_pkg::mwc_delta_type delta_in,
  input  wire logic                   sample_strobe_in,
  output logic [7:0]                  rdata_out,
  output logic [2:0]                  axis_hit_out,
  output logic [2:0]                  axis_event_out,
  output logic                        block_reset_out,
  output logic                        detect_count_enable_out
);
  import mwc_pkg::*;

  mwc_config_type   cfg_q,  cfg_d;
  logic [5:0]       th_q  [3], th_d  [3];
  logic [5:0]       cnt_q [3], cnt_d [3];
  logic [5:0]       run_q [3], run_d [3];
  logic [2:0]       hit_q,  hit_d;
  logic [2:0]       evt_q,  evt_d;
  logic [7:0]       rd_q,   rd_d;
  logic [1:0]       rst_sync_q;
  logic             rst_n;
  logic [10:0]      dl    [3];
  logic [5:0]       win   [3];
  logic [2:0]       above;

  ////////////////////////////////////////////////////////////////////////
  // Reset release through two flops
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  function automatic logic [5:0] window_sat(input logic [10:0] d, input logic [2:0] sel);
    logic [2:0]  sh;
    logic [10:0] s;
    sh = (sel > 3'h5) ? 3'h5 : sel;
    s  = d >> sh;
    // Any bit above the window clamps to full scale so big moves still hit
    window_sat = (s[10:6] != 5'h00) ? 6'h3f : s[5:0];
  endfunction

  // One-hot over X,Y,Z thresholds then X,Y,Z counts. Shared by the write
  // and read paths so both always agree on which slot an index reaches.
  // slot decode, Z count
  function automatic logic [5:0] slot_sel(input logic [2:0] idx);
    slot_sel = 6'h00;
    unique case (idx)
      MWC_IDX_TH_X:  slot_sel = 6'h01;
      MWC_IDX_TH_Y:  slot_sel = 6'h02;
      MWC_IDX_TH_Z:  slot_sel = 6'h04;
      MWC_IDX_CNT_X: slot_sel = 6'h08;
      MWC_IDX_CNT_Y: slot_sel = 6'h10;
      MWC_IDX_CNT_Z: slot_sel = 6'h20;
      default:       slot_sel = 6'h00; // Codes 0 and 4 reach nothing
    endcase
  endfunction

  assign dl[0] = delta_in.x;
  assign dl[1] = delta_in.y;
  assign dl[2] = delta_in.z;

  ////////////////////////////////////////////////////////////////////////
  // Register writes and shadow routing
  // A value write whose index reaches nothing is dropped silently, so
  // pointing at a reserved code can never corrupt a live slot.
  always_comb begin
    logic [5:0] sel;
    sel   = slot_sel(cfg_q.shadow_index_select);
    cfg_d = cfg_q;
    th_d  = th_q;
    cnt_d = cnt_q;
    if (req_in.wr && req_in.addr == MWC_CONFIG_OFFSET) begin
      cfg_d = mwc_config_type'(req_in.wdata);
    end
    if (req_in.wr && req_in.addr == MWC_VALUE_OFFSET) begin
      for (int a = 0; a < 3; a++) begin
        if (sel[a]) begin
          th_d[a] = req_in.wdata[5:0]; // Bits 7:6 are not stored
        end
        if (sel[a + 3]) begin
          cnt_d[a] = req_in.wdata[5:0];
        end
      end
    end
  end

  // Read mux, registered
  // Index comes from the config flops, so a read in the cycle after an
  // index write already sees the new slot.
  always_comb begin
    logic [5:0] rsel;
    rsel = slot_sel(cfg_q.shadow_index_select);
    rd_d = 8'h00;
    if (req_in.rd && req_in.addr == MWC_CONFIG_OFFSET) begin
      rd_d = cfg_q;
    end else if (req_in.rd && req_in.addr == MWC_VALUE_OFFSET) begin
      for (int a = 0; a < 3; a++) begin
        if (rsel[a]) begin
          rd_d = {2'h0, th_q[a]};
        end
        if (rsel[a + 3]) begin
          rd_d = {2'h0, cnt_q[a]};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-axis windowed compare
  // Runs every cycle; only a sample strobe lets a result reach the flops,
  // so a delta that moves between strobes has no effect.
  // window select, clamp
  always_comb begin
    for (int a = 0; a < 3; a++) begin
      win[a]   = window_sat(dl[a], cfg_q.delta_slice_select);
      above[a] = (win[a] > th_q[a]); // Strict: equal to threshold is no hit
    end
  end

  // Hit and event next state
  // Runs count consecutive qualifying strobes; one miss restarts the run,
  // which keeps a single noisy sample from completing a long count.
  always_comb begin
    hit_d = hit_q;
    evt_d = evt_q;
    run_d = run_q;
    if (cfg_q.block_reset) begin
      hit_d = 3'h0;
      evt_d = 3'h0;
      for (int a = 0; a < 3; a++) begin
        run_d[a] = 6'h00;
      end
    end else if (sample_strobe_in) begin
      for (int a = 0; a < 3; a++) begin
        hit_d[a] = above[a];
        if (!cfg_q.detect_count_enable) begin
          evt_d[a] = evt_q[a] | above[a];
        end else if (!above[a]) begin
          run_d[a] = 6'h00; // Qualifying events must be consecutive
        end else if (run_q[a] >= cnt_q[a]) begin
          evt_d[a] = 1'b1;
        end else begin
          run_d[a] = run_q[a] + 6'h01; // Never exceeds the stored count, no wrap
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Config and shadow registers; hardware never writes the reset bit
  // zero at reset
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= mwc_config_type'(MWC_CONFIG_RESET);
      for (int a = 0; a < 3; a++) begin
        th_q[a]  <= MWC_SHADOW_RESET;
        cnt_q[a] <= MWC_SHADOW_RESET;
      end
    end else begin
      cfg_q <= cfg_d;
      th_q  <= th_d;
      cnt_q <= cnt_d;
    end
  end

  // Read data register; zero whenever no read was taken
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      rd_q <= 8'h00;
    end else begin
      rd_q <= rd_d;
    end
  end

  // Detector state; the block reset bit clears it through the next-state logic
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      hit_q <= 3'h0;
      evt_q <= 3'h0;
      for (int a = 0; a < 3; a++) begin
        run_q[a] <= 6'h00;
      end
    end else begin
      hit_q <= hit_d;
      evt_q <= evt_d;
      run_q <= run_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs straight from flops
  assign rdata_out               = rd_q;
  assign axis_hit_out            = hit_q;
  assign axis_event_out          = evt_q;
  assign block_reset_out         = cfg_q.block_reset;
  assign detect_count_enable_out = cfg_q.detect_count_enable;

endmodule

// file: verification/mwc_sva.sv
// Purpose: Port assertions for the motion-watch config block
// Assumes: No request before the reset synchroniser settles
// Notes:   Hits depend on thresholds, so the bench judges them
module mwc_sva (
  input wire logic                   mclk_in,
  input wire logic                   arst_n_in,
  input wire mwc_pkg::mwc_req_type   req_in,
  input wire mwc_pkg::mwc_delta_type delta_in,
  input wire logic                   sample_strobe_in,
  input wire logic [7:0]             rdata_out,
  input wire logic [2:0]             axis_hit_out,
  input wire logic [2:0]             axis_event_out,
  input wire logic                   block_reset_out,
  input wire logic                   detect_count_enable_out
);
  import mwc_pkg::*;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);
  // Decoded accesses
  wire cw = req_in.wr && req_in.addr == MWC_CONFIG_OFFSET;
  wire vr = req_in.rd && req_in.addr == MWC_VALUE_OFFSET;
  wire br = block_reset_out, ce = detect_count_enable_out;
  wire ur = req_in.rd && req_in.addr != MWC_VALUE_OFFSET && req_in.addr != MWC_CONFIG_OFFSET;
  rst_wr_a: assert property (cw |=> br == $past(req_in.wdata[7])) else $error("rst");
  cnt_wr_a: assert property (cw |=> ce == $past(req_in.wdata[3])) else $error("cnt");
  val_hi_a: assert property (vr |=> rdata_out[7:6] == 2'h0) else $error("val");
  unmap_rd_a: assert property (ur |=> rdata_out == 8'h00) else $error("unmap");
  rst_keep_a: assert property (br && !cw |=> br) else $error("keep");
  rst_hold_a: assert property (br |=> (axis_hit_out | axis_event_out) == 3'h0)
    else $error("hold");
  ev_stick_a: assert property (!br |=> ($past(axis_event_out) & ~axis_event_out) == 3'h0)
    else $error("stick");
  no_count_a: assert property (sample_strobe_in && !ce && !br |=>
    (axis_hit_out & ~axis_event_out) == 3'h0) else $error("nocount");
  cover property (sample_strobe_in && delta_in.z == 11'h7ff);
  cover property (ce && $rose(axis_event_out[0]));
  cover property (br ##1 !br);
endmodule
bind mwc_motion_watch_config mwc_sva u_sva (.*);

// file: verification/mwc_host_model.sv
// Purpose: Host model on the byte-wide register port
// Assumes: Requests change at falling edges only
// Notes:   Idle bus shows inverted payload, never stale values
module mwc_host_model (
  input  wire logic            mclk_in,
  input  wire logic [7:0]      rdata_in,
  output mwc_pkg::mwc_req_type req_out
);
  import mwc_pkg::*;
  initial req_out = '0;
  // Each strobe spans exactly one rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_in) req_out = '{1'b1, 1'b0, a, d};
    @(negedge mclk_in) req_out = '{1'b0, 1'b0, ~a, ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk_in) req_out = '{1'b0, 1'b1, a, 8'h00};
    @(negedge mclk_in) d = rdata_in;
    req_out = '{1'b0, 1'b0, ~a, 8'hff};
  endtask
endmodule

// file: verification/mwc_motion_watch_config_tb.sv
// Purpose: Self-checking bench for the motion-watch config block
// Assumes: Host model owns the register port
// Notes:   Deltas come from a fixed-seed shift register
module mwc_motion_watch_config_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mwc_pkg::*;
  logic          mclk_in = 1'b0, arst_n_in = 1'b0, sample_strobe_in = 1'b0;
  logic          block_reset_out, detect_count_enable_out;
  logic [2:0]    axis_hit_out, axis_event_out, sh, eh, ev = 3'h0;
  logic [7:0]    rdata_out, got, shadow [8];
  logic [15:0]   rnd = 16'h688b;
  mwc_delta_type delta_in = '0, d;
  mwc_req_type   req;
  int            miscompares = 0, num_checks = 0;
  mwc_motion_watch_config u_dut (.mclk_in, .arst_n_in, .req_in(req), .delta_in,
    .sample_strobe_in, .rdata_out, .axis_hit_out, .axis_event_out, .block_reset_out,
    .detect_count_enable_out);
  mwc_host_model u_host (.mclk_in, .rdata_in(rdata_out), .req_out(req));
  // Clock, and a cycle ceiling far past the planned run
  initial forever #4 mclk_in = ~mclk_in;
  initial begin
    repeat (5000) @(posedge mclk_in);
    miscompares++;
    results();
  end
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  // Shifted delta clamps to all ones once it overflows six bits
  function automatic logic hit(input logic [10:0] v, input int a);
    return ((v >> sh) > 11'h03f ? 6'h3f : 6'(v >> sh)) > shadow[a][5:0];
  endfunction
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s === e) return;
    $display("Error %s expected %h seen %h", n, e, s);
    miscompares++;
  endtask
  task automatic results();
    if (miscompares == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic smp();
    @(negedge mclk_in);
    delta_in = d;
    sample_strobe_in = 1'b1;
    @(negedge mclk_in);
    sample_strobe_in = 1'b0;
  endtask
  initial begin
    repeat (20) @(negedge mclk_in);
    arst_n_in = 1'b1;
    repeat (3) @(negedge mclk_in);
    u_host.rd(8'h15, got);
    chk("unmapped", got, 8'h00);
    u_host.rd(8'h14, got);
    chk("config reset", got, 8'h00);
    // All slots written before any readback, so aliasing shows
    for (int i = 0; i < 16; i++) begin
      rnd = lfsr(rnd);
      if (i < 8) shadow[i] = (i % 4 == 0) ? 8'h00 : {2'h0, rnd[5:0]};
      u_host.wr(8'h14, 8'(i % 8));
      if (i < 8) u_host.wr(8'h13, rnd[7:0]);
      else u_host.rd(8'h13, got);
      if (i > 7) chk("shadow", got, shadow[i % 8]);
    end
    // Random config byte reads back whole; no strobe has come yet
    rnd = lfsr(rnd);
    u_host.wr(8'h14, rnd[7:0]);
    u_host.rd(8'h14, got);
    chk("config", got, rnd[7:0]);
    // Every selector code; first pass drives Z to full scale, past the window for codes 0-4
    for (int k = 0; k < 32; k++) begin
      rnd = lfsr(rnd);
      d = '{rnd[10:0], rnd[15:5], (k < 8) ? 11'h7ff : rnd[12:2]};
      sh = (k % 8 > 5) ? 3'h5 : 3'(k % 8);
      u_host.wr(8'h14, {1'b0, 3'(k % 8), 4'h0});
      smp();
      eh = {hit(d.z, 3), hit(d.y, 2), hit(d.x, 1)};
      ev = ev | eh;
      chk("hit", {5'h00, axis_hit_out}, {5'h00, eh});
      chk("sticky", {5'h00, axis_event_out}, {5'h00, ev});
    end
    d = '{11'h7ff, 11'h000, 11'h000};
    u_host.wr(8'h14, 8'h88);
    smp();
    chk("held", {2'h0, axis_hit_out, axis_event_out}, 8'h00);
    u_host.wr(8'h14, 8'h01);
    u_host.wr(8'h13, 8'h00);
    u_host.wr(8'h14, 8'h05);
    u_host.wr(8'h13, 8'h01);
    u_host.wr(8'h14, 8'h08);
    for (int j = 0; j < 2; j++) begin
      smp();
      chk("event", {7'h00, axis_event_out[0]}, 8'(j));
    end
    results();
  end
endmodule
